// File: rpc_pkg.sv
/*
 * constants for the redriver power-state sequencer
 * assumes a 25 MHz pclk and an APB register bus
 */
package rpc_pkg;
    // ----------------------------------------
    // clock and time base
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int OSC_TICK_NS = 1000;            // startup oscillator period
    localparam int OSC_DIV = OSC_TICK_NS / CLK_PERIOD_NS;
    localparam int LP1_TIME_MS = 2;
    localparam int DEBOUNCE_TIME_MS = 300;
    localparam int LP1_TICKS = LP1_TIME_MS * 1000000 / OSC_TICK_NS;
    localparam int DEBOUNCE_TICKS = DEBOUNCE_TIME_MS * 1000000 / OSC_TICK_NS;
    localparam int TIMER_W = 20;
    localparam int DIV_W = 8;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    localparam int CTRL_LINK_PD_BIT = 0;
    localparam int CTRL_AUTO_MON_BIT = 1;
    localparam int CTRL_CS_LSB = 4;
    localparam int CTRL_EQ_LSB = 8;
    localparam logic [3:0] CS_RESET = 4'hf;
    localparam logic [3:0] EQ_RESET = 4'h0;
    // ----------------------------------------
    // fixed gain codes for the three-level pin
    // ----------------------------------------
    localparam logic [1:0] LEVEL_LOW = 2'h0;
    localparam logic [1:0] LEVEL_MID = 2'h1;
    localparam logic [1:0] LEVEL_HIGH = 2'h3;
    localparam logic [3:0] EQ_PIN_LOW = 4'h0;
    localparam logic [3:0] EQ_PIN_MID = 4'hc;
    localparam logic [3:0] EQ_PIN_HIGH = 4'hf;
    // ----------------------------------------
    // sequencer states, gray along the usual path
    // ----------------------------------------
    typedef enum logic [2:0] {
        state_reset = 3'h0,
        state_low_power_one = 3'h1,
        state_low_power_two = 3'h3,
        state_active = 3'h2,
        state_debounce_wait = 3'h6
    } rpc_state_type;
endpackage

// File: rpc_power_seq.sv
/*
 * power-state sequencer of a four-lane video redriver with APB registers
 * assumes synchronous pins, presetn as power-on reset, pclk at 25 MHz
 */
// Local design decisions: the register offsets and the APB register port.
// How it works
// [R1] enable low holds power-down, all outputs released; high runs normally
// [R2] host keeps enable low until supply is stable
// [R3] host keeps enable low at least 100 us for a clean reset
// [R4] host rewrites programmed settings after every enable reset
// [R5] power-on starts in reset state with channels off
// [R6] reset release enters low power one, after 2 ms low power two
// [R7] hot-plug high in low power two enters active
// [R8] active turns regulator on; lanes follow its power-good
// [R9] hot-plug low in active enters wait and starts debounce
// [R10] hot-plug still low after 300 ms returns to low power two
// [R11] hot-plug back high within 300 ms returns to active
// [R12] active and wait keep every block powered
// [R13] in packet mode with one or two live lanes, others power off
// [R14] no input video powers the whole chip down
// [R15] optionally, no monitor powers the whole chip down
// [R16] link power-down register bit also powers down
// [R17] regulator and lanes on only in active or wait with select set
// [R18] unselected lanes always stay off
// [R19] display data pins pass through only while cable detect is high
// [R20] adaptive gain select low takes gain from three-level pin
// [R21] 2 ms and 300 ms timed on oscillator ticks; debounce restarts
`timescale 1ns/1ps
`default_nettype none
module rpc_power_seq #(
    parameter int LANES = 4,
    parameter int LP1_TICKS = rpc_pkg::LP1_TICKS,
    parameter int DEBOUNCE_TICKS = rpc_pkg::DEBOUNCE_TICKS
) (
    // clock and power-on reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins and analog status
    input wire logic enable_in,
    input wire logic sink_hotplug_in,
    input wire logic sink_cable_detect_in,
    input wire logic adaptive_gain_select,
    input wire logic [1:0] gain_level_pin,
    input wire logic reg_power_good_in,
    input wire logic [LANES-1:0] lane_signal_in,
    // power controls
    output logic reg_enable,
    output logic [LANES-1:0] lane_power,
    output logic [3:0] eq_setting,
    output logic outputs_enable,
    // display data channel, source side and sink side
    input wire logic display_data_clock_pin_in,
    output logic display_data_clock_pin_out,
    output logic display_data_clock_pin_oe,
    input wire logic display_data_line_pin_in,
    output logic display_data_line_pin_out,
    output logic display_data_line_pin_oe,
    input wire logic sink_data_clock_in,
    output logic sink_data_clock_out,
    output logic sink_data_clock_oe,
    input wire logic sink_data_line_in,
    output logic sink_data_line_out,
    output logic sink_data_line_oe
);
    // ----------------------------------------
    // state record
    // ----------------------------------------
    typedef struct packed {
        rpc_pkg::rpc_state_type st;
        logic [rpc_pkg::DIV_W-1:0] div;
        logic tick;
        logic [rpc_pkg::TIMER_W-1:0] timer;
        logic link_pd;
        logic auto_mon;
        logic [3:0] cs;
        logic [3:0] eq_reg;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        logic reg_en;
        logic [LANES-1:0] lanes;
        logic [3:0] eq;
        logic out_en;
        logic ck_src_oe;
        logic dl_src_oe;
        logic ck_snk_oe;
        logic dl_snk_oe;
    } rpc_regs_type;

    rpc_regs_type r_q;
    rpc_regs_type r_d;

    localparam logic [rpc_pkg::DIV_W-1:0] DIV_LAST =
        rpc_pkg::DIV_W'(rpc_pkg::OSC_DIV - 1);
    localparam logic [rpc_pkg::TIMER_W-1:0] LP1_LAST =
        rpc_pkg::TIMER_W'(LP1_TICKS - 1);
    localparam logic [rpc_pkg::TIMER_W-1:0] DEB_LAST =
        rpc_pkg::TIMER_W'(DEBOUNCE_TICKS - 1);

    // ----------------------------------------
    // next-state logic
    // ----------------------------------------
    logic chip_pd;
    logic in_run;
    logic few_lanes;
    logic [2:0] live;
    logic setup;
    logic wr_go;
    logic hit_ctrl;
    logic hit_stat;

    // all sequencing, register and power decisions in one pass
    always_comb begin
        r_d = r_q;
        live = 3'h0;
        for (int i = 0; i < LANES; i++) begin
            live = live + {2'h0, lane_signal_in[i]};
        end
        // startup oscillator tick from the pclk divider
        r_d.tick = 1'b0;
        if (r_q.div == DIV_LAST) begin
            r_d.div = '0;
            r_d.tick = 1'b1;
        end else begin
            r_d.div = r_q.div + 1'b1;
        end
        // sequencer; the two timed states count oscillator ticks, hot-plug moves act on any pclk
        case (r_q.st)
            rpc_pkg::state_reset: begin
                r_d.timer = '0;
                r_d.st = rpc_pkg::state_low_power_one; // [R6]
            end
            rpc_pkg::state_low_power_one: begin
                if (r_q.tick) begin
                    if (r_q.timer == LP1_LAST) begin
                        r_d.st = rpc_pkg::state_low_power_two; // [R6]
                    end else begin
                        r_d.timer = r_q.timer + 1'b1; // [R21]
                    end
                end
            end
            rpc_pkg::state_low_power_two: begin
                if (sink_hotplug_in) begin
                    r_d.st = rpc_pkg::state_active; // [R7]
                end
            end
            rpc_pkg::state_active: begin
                if (!sink_hotplug_in) begin
                    r_d.timer = '0; // [R21]
                    r_d.st = rpc_pkg::state_debounce_wait; // [R9]
                end
            end
            rpc_pkg::state_debounce_wait: begin
                if (sink_hotplug_in) begin
                    r_d.st = rpc_pkg::state_active; // [R11]
                end else if (r_q.tick) begin
                    if (r_q.timer == DEB_LAST) begin
                        r_d.st = rpc_pkg::state_low_power_two; // [R10]
                    end else begin
                        r_d.timer = r_q.timer + 1'b1; // [R21]
                    end
                end
            end
            default: begin
                r_d.st = rpc_pkg::state_reset;
            end
        endcase
        // enable low forces the power-down reset state
        if (!enable_in) begin
            r_d.st = rpc_pkg::state_reset; // [R1]
            r_d.timer = '0;
        end
        // whole-chip power-down causes
        chip_pd = !enable_in || r_q.link_pd // [R16]
            || (lane_signal_in == '0) // [R14]
            || (r_q.auto_mon && !sink_hotplug_in); // [R15]
        in_run = (r_q.st == rpc_pkg::state_active)
            || (r_q.st == rpc_pkg::state_debounce_wait); // [R12]
        few_lanes = !sink_cable_detect_in && (live != 3'h0) && (live < 3'h3);
        // regulator follows state and select decode; wait keeps it up
        r_d.reg_en = in_run && (r_q.cs != 4'h0) // [R12]
            && !chip_pd; // [R17]
        for (int i = 0; i < LANES; i++) begin
            r_d.lanes[i] = r_q.reg_en && reg_power_good_in // [R8]
                && r_d.reg_en && r_q.cs[i] // [R18]
                && (!few_lanes || lane_signal_in[i]); // [R13]
        end
        r_d.out_en = enable_in; // [R1]
        // gain source: fixed pin or register
        if (!adaptive_gain_select) begin
            case (gain_level_pin)
                rpc_pkg::LEVEL_LOW: r_d.eq = rpc_pkg::EQ_PIN_LOW; // [R20]
                rpc_pkg::LEVEL_MID: r_d.eq = rpc_pkg::EQ_PIN_MID; // [R20]
                rpc_pkg::LEVEL_HIGH: r_d.eq = rpc_pkg::EQ_PIN_HIGH; // [R20]
                default: r_d.eq = rpc_pkg::EQ_PIN_MID;
            endcase
        end else begin
            r_d.eq = r_q.eq_reg;
        end
        // display data pass-through, never echoing our own pull-down
        r_d.ck_src_oe = enable_in && sink_cable_detect_in // [R19]
            && !sink_data_clock_in && !r_q.ck_snk_oe;
        r_d.dl_src_oe = enable_in && sink_cable_detect_in // [R19]
            && !sink_data_line_in && !r_q.dl_snk_oe;
        r_d.ck_snk_oe = enable_in && sink_cable_detect_in // [R19]
            && !display_data_clock_pin_in && !r_q.ck_src_oe;
        r_d.dl_snk_oe = enable_in && sink_cable_detect_in // [R19]
            && !display_data_line_pin_in && !r_q.dl_src_oe;
        // apb: answer prepared in setup, completed in first access cycle
        setup = psel && !penable;
        wr_go = psel && penable && r_q.ready && pwrite;
        hit_ctrl = (paddr == rpc_pkg::CTRL_ADDR);
        hit_stat = (paddr == rpc_pkg::STATUS_ADDR);
        r_d.ready = setup;
        r_d.slverr = setup && !hit_ctrl && !hit_stat;
        if (setup) begin
            r_d.rdata = '0;
            if (hit_ctrl) begin
                r_d.rdata[rpc_pkg::CTRL_LINK_PD_BIT] = r_q.link_pd;
                r_d.rdata[rpc_pkg::CTRL_AUTO_MON_BIT] = r_q.auto_mon;
                r_d.rdata[rpc_pkg::CTRL_CS_LSB +: 4] = r_q.cs;
                r_d.rdata[rpc_pkg::CTRL_EQ_LSB +: 4] = r_q.eq_reg;
            end else if (hit_stat) begin
                r_d.rdata = {14'h0, r_q.eq, r_q.lanes, r_q.reg_en,
                    reg_power_good_in, 2'h0, sink_cable_detect_in,
                    sink_hotplug_in, 1'b0, r_q.st};
            end
        end
        if (wr_go && hit_ctrl) begin
            r_d.link_pd = pwdata[rpc_pkg::CTRL_LINK_PD_BIT];
            r_d.auto_mon = pwdata[rpc_pkg::CTRL_AUTO_MON_BIT];
            r_d.cs = pwdata[rpc_pkg::CTRL_CS_LSB +: 4];
            r_d.eq_reg = pwdata[rpc_pkg::CTRL_EQ_LSB +: 4];
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    // power-on reset puts the sequencer in its reset state, all off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q <= '0; // [R5]
            r_q.st <= rpc_pkg::state_reset; // [R5]
            r_q.cs <= rpc_pkg::CS_RESET;
            r_q.eq_reg <= rpc_pkg::EQ_RESET;
        end else begin
            r_q <= r_d;
        end
    end

    // ----------------------------------------
    // outputs from flip-flops, data pin out levels tied low
    // ----------------------------------------
    assign prdata = r_q.rdata;
    assign pready = r_q.ready;
    assign pslverr = r_q.slverr;
    assign reg_enable = r_q.reg_en;
    assign lane_power = r_q.lanes;
    assign eq_setting = r_q.eq;
    assign outputs_enable = r_q.out_en;
    assign display_data_clock_pin_out = 1'b0; // open drain, low only
    assign display_data_clock_pin_oe = r_q.ck_src_oe;
    assign display_data_line_pin_out = 1'b0;
    assign display_data_line_pin_oe = r_q.dl_src_oe;
    assign sink_data_clock_out = 1'b0;
    assign sink_data_clock_oe = r_q.ck_snk_oe;
    assign sink_data_line_out = 1'b0;
    assign sink_data_line_oe = r_q.dl_snk_oe;
endmodule // rpc_power_seq
`default_nettype wire

// File: rpc_power_seq_asserts.sv
/* assertions on the sequencer pins and apb answers
   bound to rpc_power_seq, sees its ports only */
`timescale 1ns/1ps
`default_nettype none
module rpc_power_seq_asserts #(
    parameter int LANES = 4
) (
    // clock, reset, apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // pins
    input wire logic enable_in,
    input wire logic sink_cable_detect_in,
    input wire logic reg_power_good_in,
    input wire logic [LANES-1:0] lane_signal_in,
    input wire logic reg_enable,
    input wire logic [LANES-1:0] lane_power,
    input wire logic outputs_enable,
    input wire logic sink_data_clock_in,
    input wire logic display_data_clock_pin_oe,
    input wire logic display_data_line_pin_in,
    input wire logic sink_data_line_oe
);
    // --------
    // properties
    // --------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_off_disabled:
        assert property (!enable_in |=> !outputs_enable)
        else $error("outputs driven while disabled");
    chk_down_disabled:
        assert property (!enable_in [*2] |=> !reg_enable && lane_power == '0)
        else $error("power on while disabled");
    chk_lanes_good:
        assert property (lane_power != '0 |->
            $past(reg_enable && reg_power_good_in))
        else $error("lanes on before power good");
    chk_zero_wait:
        assert property (psel && !penable |=> pready)
        else $error("apb answer late");
    chk_ready_access:
        assert property (pready |-> psel && penable && $past(psel && !penable))
        else $error("pready outside access phase");
    chk_unmapped_err:
        assert property (pready |-> pslverr == (paddr != rpc_pkg::CTRL_ADDR
            && paddr != rpc_pkg::STATUS_ADDR))
        else $error("wrong error response");
    chk_no_signal_off:
        assert property ((lane_signal_in == '0) [*4] |->
            lane_power == '0 && !reg_enable)
        else $error("powered without input signal");
    chk_ddc_clock:
        assert property (display_data_clock_pin_oe |->
            $past(sink_cable_detect_in && !sink_data_clock_in))
        else $error("clock pulled without cause");
    chk_ddc_line:
        assert property (sink_data_line_oe |->
            $past(sink_cable_detect_in && !display_data_line_pin_in))
        else $error("line pulled without cause");
endmodule // rpc_power_seq_asserts
bind rpc_power_seq rpc_power_seq_asserts #(.LANES(LANES)) u_chk (
    .pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr,
    .enable_in, .sink_cable_detect_in, .reg_power_good_in,
    .lane_signal_in, .reg_enable, .lane_power, .outputs_enable,
    .sink_data_clock_in, .display_data_clock_pin_oe,
    .display_data_line_pin_in, .sink_data_line_oe
);
`default_nettype wire

// File: rpc_host_model.sv
/* host controller and sink model: enable pin, hot-plug, regulator
   assumes the bench calls its tasks just after a pclk edge */
`timescale 1ns/1ps
`default_nettype none
module rpc_host_model (
    // clock and regulator control
    input wire logic pclk,
    input wire logic reg_enable,
    // pins toward the sequencer
    output logic enable_in,
    output logic sink_hotplug_in,
    output logic reg_power_good_in
);
    // --------
    // behaviour
    // --------
    logic [2:0] ramp_q = 3'h0;
    initial enable_in = 1'b0;
    initial sink_hotplug_in = 1'b0;
    // regulator output needs three cycles to report good
    always @(posedge pclk) ramp_q <= reg_enable ? {ramp_q[1:0], 1'b1} : 3'h0;
    assign reg_power_good_in = ramp_q[2];
    task set_hpd(input logic v);
        @(posedge pclk);
        sink_hotplug_in <= v;
    endtask
    // enable rises only once the supply has settled
    task power_on();
        @(posedge pclk);
        enable_in <= 1'b1;
    endtask
    // low for more than 100 us gives a clean reset
    task power_cycle();
        @(posedge pclk);
        enable_in <= 1'b0;
        repeat (2600) @(posedge pclk);
        enable_in <= 1'b1;
    endtask
endmodule // rpc_host_model
`default_nettype wire

// File: redriver_power_state_control_test.sv
/* self-checking bench for the power sequencer
   apb and pins from here, enable and hot-plug from the host model */
`timescale 1ns/1ps
`default_nettype none
module redriver_power_state_control_test;
    // --------
    // signals and design
    // --------
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, err, outputs_enable;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic enable_in, sink_hotplug_in, reg_power_good_in, reg_enable;
    logic sink_cable_detect_in = 1'b0, adaptive_gain_select = 1'b1;
    logic scl_low = 1'b0, sda_low = 1'b0;
    logic [1:0] gain_level_pin = 2'h1;
    logic [3:0] lane_signal_in = 4'hf, lane_power, eq_setting;
    wire logic dck_in, dck_oe, dln_in, dln_oe, sck_in, sck_oe, sln_in, sln_oe;
    wire logic dck_out, dln_out, sck_out, sln_out;
    int n_fail = 0, tests_run = 0;
    // open-drain wires are low while any party pulls
    assign dck_in = !dck_oe | dck_out;
    assign dln_in = (!dln_oe | dln_out) & !sda_low;
    assign sck_in = (!sck_oe | sck_out) & !scl_low;
    assign sln_in = !sln_oe | sln_out;
    always #20 pclk = ~pclk;
    rpc_power_seq #(.LP1_TICKS(5), .DEBOUNCE_TICKS(20)) dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .enable_in, .sink_hotplug_in,
        .sink_cable_detect_in, .adaptive_gain_select, .gain_level_pin,
        .reg_power_good_in, .lane_signal_in, .reg_enable, .lane_power,
        .eq_setting, .outputs_enable, .display_data_clock_pin_in(dck_in),
        .display_data_clock_pin_out(dck_out),
        .display_data_clock_pin_oe(dck_oe),
        .display_data_line_pin_in(dln_in),
        .display_data_line_pin_out(dln_out),
        .display_data_line_pin_oe(dln_oe), .sink_data_clock_in(sck_in),
        .sink_data_clock_out(sck_out), .sink_data_clock_oe(sck_oe),
        .sink_data_line_in(sln_in), .sink_data_line_out(sln_out),
        .sink_data_line_oe(sln_oe)
    );
    rpc_host_model hm (.pclk, .reg_enable, .enable_in, .sink_hotplug_in,
        .reg_power_good_in);
    // --------
    // helpers
    // --------
    task cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h, want %h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task st(input logic [2:0] e);
        apb(1'b0, rpc_pkg::STATUS_ADDR, 32'h0);
        check(rd[2:0], e);
    endtask
    task stop_test();
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // --------
    // scenarios
    // --------
    task t_start();
        st(rpc_pkg::state_reset);
        apb(1'b0, rpc_pkg::CTRL_ADDR, 32'h0);
        check(rd, 32'h000000f0);
        hm.power_on();
        cyc(50);
        st(rpc_pkg::state_low_power_one);
        check(outputs_enable, 1'b1);
        cyc(150);
        st(rpc_pkg::state_low_power_two);
        check(reg_enable, 1'b0);
        $display("start done");
    endtask
    task t_track();
        hm.set_hpd(1'b1);
        cyc(12);
        st(rpc_pkg::state_active);
        check(lane_power, 4'hf);
        hm.set_hpd(1'b0);
        cyc(4);
        st(rpc_pkg::state_debounce_wait);
        check(lane_power, 4'hf);
        cyc(370);
        hm.set_hpd(1'b1);
        cyc(4);
        st(rpc_pkg::state_active);
        hm.set_hpd(1'b0);
        cyc(370);
        st(rpc_pkg::state_debounce_wait);
        cyc(200);
        st(rpc_pkg::state_low_power_two);
        check(lane_power, 4'h0);
        $display("hot-plug done");
    endtask
    task t_lanes();
        hm.set_hpd(1'b1);
        lane_signal_in <= 4'h3;
        cyc(12);
        check(lane_power, 4'h3);
        apb(1'b1, rpc_pkg::CTRL_ADDR, 32'h10);
        cyc(6);
        check(lane_power, 4'h1);
        apb(1'b1, rpc_pkg::CTRL_ADDR, 32'h00);
        cyc(6);
        check(reg_enable, 1'b0);
        apb(1'b1, rpc_pkg::CTRL_ADDR, 32'hf1);
        cyc(6);
        check(reg_enable, 1'b0);
        apb(1'b1, rpc_pkg::CTRL_ADDR, 32'hf2);
        hm.set_hpd(1'b0);
        cyc(6);
        check(reg_enable, 1'b0);
        apb(1'b1, rpc_pkg::CTRL_ADDR, 32'hf0);
        hm.set_hpd(1'b1);
        lane_signal_in <= 4'h0;
        cyc(8);
        check(reg_enable, 1'b0);
        lane_signal_in <= 4'hf;
        // unmapped word answers with an error and zero data
        apb(1'b0, 8'h08, 32'h0);
        check(err, 1'b1);
        check(rd, 32'h0);
        $display("lanes done");
    endtask
    task eqp(input logic [1:0] l, input logic [3:0] e);
        gain_level_pin <= l;
        cyc(3);
        check(eq_setting, e);
    endtask
    task t_eq_ddc();
        // adaptive select high takes the gain from the register
        apb(1'b1, rpc_pkg::CTRL_ADDR, 32'h5f0);
        cyc(2);
        check(eq_setting, 4'h5);
        adaptive_gain_select <= 1'b0;
        eqp(rpc_pkg::LEVEL_LOW, rpc_pkg::EQ_PIN_LOW);
        eqp(rpc_pkg::LEVEL_MID, rpc_pkg::EQ_PIN_MID);
        eqp(rpc_pkg::LEVEL_HIGH, rpc_pkg::EQ_PIN_HIGH);
        sink_cable_detect_in <= 1'b1;
        scl_low <= 1'b1;
        sda_low <= 1'b1;
        cyc(4);
        check({dck_in, sln_oe}, 2'b01);
        sink_cable_detect_in <= 1'b0;
        cyc(4);
        check({dck_in, sln_oe}, 2'b10);
        scl_low <= 1'b0;
        sda_low <= 1'b0;
        $display("gain and data channel done");
    endtask
    task t_enable();
        fork
            hm.power_cycle();
            begin
                cyc(10);
                check(outputs_enable, 1'b0);
                st(rpc_pkg::state_reset);
            end
        join
        cyc(4);
        check(outputs_enable, 1'b1);
        st(rpc_pkg::state_low_power_one);
        apb(1'b1, rpc_pkg::CTRL_ADDR, 32'hf0);
        $display("enable reset done");
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_start();
        t_track();
        t_lanes();
        t_eq_ddc();
        t_enable();
        stop_test();
    end
    // watchdog against a hung handshake
    initial begin
        cyc(10000);
        n_fail++;
        stop_test();
    end
endmodule // redriver_power_state_control_test
`default_nettype wire
